// ===== shared/rpc_pkg.sv
/*
 * Shared constants and types of the serial printer/controller port:
 * register map, field positions, reset values, baud timing, states.
 * Assumes a 100 MHz APB clock and 32-bit APB data.
 */
package rpc_pkg;

	// Clock and baud timing
	localparam int CLK_HZ_DEF = 100_000_000;
	localparam int OVS = 16;
	localparam int OVS_MID = 7;
	localparam int BAUD_300 = 300;
	localparam int BAUD_1200 = 1200;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int STOP_BITS_TX = 2;

	// Register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_TXDATA = 12'h008;
	localparam logic [11:0] ADDR_RXDATA = 12'h00C;
	localparam logic [11:0] ADDR_PROMPT = 12'h010;
	localparam logic [11:0] ADDR_CMD = 12'h014;

	// Control register fields, control and prompt reset values
	localparam int CTRL_BAUD_LSB = 0;
	localparam int CTRL_DATA8 = 3;
	localparam int CTRL_PAR_LSB = 4;
	localparam int CTRL_INTER = 6;
	localparam int CTRL_GRAPH = 7;
	localparam logic [7:0] CTRL_RESET = 8'h4C;
	localparam logic [7:0] PROMPT_RESET = 8'h3E;

	// Status and command register fields
	localparam int STAT_RXV = 0;
	localparam int STAT_HOLD = 1;
	localparam int STAT_BUSY = 2;
	localparam int STAT_OVR = 3;
	localparam int STAT_PERR = 4;
	localparam int STAT_FERR = 5;
	localparam int STAT_DTR = 6;
	localparam int STAT_CTS = 7;
	localparam int CMD_READY = 0;

	// Baud selections
	localparam logic [2:0] SEL_300 = 3'h0;
	localparam logic [2:0] SEL_1200 = 3'h1;
	localparam logic [2:0] SEL_2400 = 3'h2;
	localparam logic [2:0] SEL_4800 = 3'h3;

	// Parity selections
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PAR = 3'b011,
		TX_STOP = 3'b100
	} rpc_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PAR = 3'b011,
		RX_STOP = 3'b100
	} rpc_rx_e;

	// Character format as software sets it
	typedef struct packed {
		logic graphics;
		logic interactive;
		logic [1:0] parity;
		logic data8;
		logic [2:0] baud;
	} rpc_cfg_s;

	// Received data and status lines toward the terminal equipment
	typedef struct packed {
		logic rd;
		logic cts;
		logic dsr;
		logic rlsd;
	} rpc_line_s;

	typedef struct packed {
		rpc_cfg_s cfg;
		logic [7:0] prompt;
		logic [7:0] hold;
		logic hold_v;
		logic [7:0] echo;
		logic echo_v;
		logic prompt_v;
		rpc_tx_e tx_st;
		logic [7:0] tx_sh;
		logic [2:0] tx_bit;
		logic [3:0] tx_ph;
		logic tx_par;
		rpc_rx_e rx_st;
		logic [7:0] rx_sh;
		logic [2:0] rx_bit;
		logic [3:0] rx_ph;
		logic [7:0] rx_data;
		logic rx_v;
		logic ovr;
		logic perr;
		logic ferr;
		rpc_line_s line;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rpc_state_s;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} rpc_bg_s;

endpackage

// ===== verilog/rpc_baud_gen.sv
/*
 * Oversampling tick generator: one-cycle enable at sixteen times the
 * selected baud rate. Assumes the selection is stable between frames.
 */
`timescale 1ns/10ps
module rpc_baud_gen import rpc_pkg::*; #(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Rate selection
	input wire logic [2:0] sel,
	// Oversample enable
	output logic tick
);

	// Rounded divisor for one oversample period
	function automatic logic [15:0] rpc_div(input logic [2:0] s);
		int b;
		if (s == SEL_300) begin
			b = BAUD_300;
		end else if (s == SEL_1200) begin
			b = BAUD_1200;
		end else if (s == SEL_2400) begin
			b = BAUD_2400;
		end else if (s == SEL_4800) begin
			b = BAUD_4800;
		end else begin
			b = BAUD_9600;
		end
		return 16'((CLK_HZ + b * OVS / 2) / (b * OVS));
	endfunction

	rpc_bg_s q, d;

	////////////////////////////////////////////////////////////////////
	// Down counter, reloads on expiry
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt <= 16'h0001) begin
			d.cnt = rpc_div(sel);
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

endmodule

// ===== verilog/rpc_port.sv
/*
 * Asynchronous serial printer/controller port, DCE side, with APB
 * register access. Assumes td and dtr are synchronous to pclk and that
 * the APB master keeps the request stable until pready.
 */
`timescale 1ns/10ps
module rpc_port import rpc_pkg::*; #(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line, DCE side
	input wire logic td,
	input wire logic dtr,
	output logic rd,
	output logic cts,
	output logic dsr,
	output logic rlsd
);

	rpc_state_s q, d;
	logic tick;

	// Keep only the configured number of data bits
	function automatic logic [7:0] rpc_mask(input logic [7:0] v,
			input logic data8);
		return data8 ? v : {1'b0, v[6:0]};
	endfunction

	// Parity bit over the configured data bits
	function automatic logic rpc_parity(input logic [7:0] v,
			input rpc_cfg_s c);
		return (^rpc_mask(v, c.data8)) ^ (c.parity == PAR_ODD);
	endfunction

	// Parity enabled for this format
	function automatic logic rpc_par_on(input rpc_cfg_s c);
		return (c.parity == PAR_EVEN) || (c.parity == PAR_ODD);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Baud timing
	rpc_baud_gen #(
		.CLK_HZ(CLK_HZ)
	) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.sel(q.cfg.baud),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, transmitter, receiver
	always_comb begin
		logic acc;
		logic [7:0] nxt;
		logic last;
		acc = 1'b0;
		nxt = 8'h00;
		last = 1'b0;
		d = q;

		// Bus: one wait state, answer registered
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (psel && penable && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = 32'h0000_0000;
			if (paddr == ADDR_CTRL) begin
				d.prdata[7:0] = q.cfg;
			end else if (paddr == ADDR_STAT) begin
				d.prdata[STAT_RXV] = q.rx_v;
				d.prdata[STAT_HOLD] = q.hold_v;
				d.prdata[STAT_BUSY] = q.tx_st != TX_IDLE;
				d.prdata[STAT_OVR] = q.ovr;
				d.prdata[STAT_PERR] = q.perr;
				d.prdata[STAT_FERR] = q.ferr;
				d.prdata[STAT_DTR] = dtr;
				d.prdata[STAT_CTS] = q.line.cts;
			end else if (paddr == ADDR_RXDATA) begin
				d.prdata[7:0] = q.rx_data;
			end else if (paddr == ADDR_PROMPT) begin
				d.prdata[7:0] = q.prompt;
			end else if (paddr == ADDR_TXDATA || paddr == ADDR_CMD) begin
				d.prdata = 32'h0000_0000;
			end else begin
				d.pslverr = 1'b1;
			end
			// Writes answer with zero data, whatever the address
			if (pwrite) begin
				d.prdata = 32'h0000_0000;
			end
		end

		// Register effects at the completing edge
		acc = psel && penable && q.pready;
		if (acc && pwrite) begin
			if (paddr == ADDR_CTRL) begin
				d.cfg = pwdata[7:0];
			end else if (paddr == ADDR_STAT) begin
				// Write one to clear error flags
				if (pwdata[STAT_OVR]) d.ovr = 1'b0;
				if (pwdata[STAT_PERR]) d.perr = 1'b0;
				if (pwdata[STAT_FERR]) d.ferr = 1'b0;
			end else if (paddr == ADDR_TXDATA) begin
				// A full holding register refuses the byte
				if (!q.hold_v) begin
					d.hold = pwdata[7:0];
					d.hold_v = 1'b1;
				end
			end else if (paddr == ADDR_PROMPT) begin
				d.prompt = pwdata[7:0];
			end else if (paddr == ADDR_CMD) begin
				// Prompt only when a terminal is attached
				if (pwdata[CMD_READY] && q.cfg.interactive) begin
					d.prompt_v = 1'b1;
				end
			end
		end
		if (acc && !pwrite && paddr == ADDR_RXDATA) begin
			d.rx_v = 1'b0;
		end

		// Transmitter, stepped by the oversample tick
		if (tick) begin
			last = q.tx_ph == 4'(OVS - 1);
			d.tx_ph = q.tx_ph + 4'h1;
			case (q.tx_st)
				TX_IDLE: begin
					d.tx_ph = 4'h0;
					// Echo first so a typed line reads back in order
					if (dtr && (q.echo_v || q.prompt_v || q.hold_v)) begin
						if (q.echo_v) begin
							nxt = q.echo;
							d.echo_v = 1'b0;
						end else if (q.prompt_v) begin
							nxt = q.prompt;
							d.prompt_v = 1'b0;
						end else begin
							nxt = q.hold;
							d.hold_v = 1'b0;
						end
						// Text is plain ASCII unless graphics bytes allowed
						if (!q.cfg.graphics) begin
							nxt[7] = 1'b0;
						end
						nxt = rpc_mask(nxt, q.cfg.data8);
						d.tx_sh = nxt;
						d.tx_par = rpc_parity(nxt, q.cfg);
						d.tx_st = TX_START;
						d.line.rd = 1'b0;
					end
				end
				TX_START: begin
					if (last) begin
						d.tx_st = TX_DATA;
						d.tx_bit = 3'h0;
						d.line.rd = q.tx_sh[0];
					end
				end
				TX_DATA: begin
					if (last) begin
						d.tx_sh = {1'b0, q.tx_sh[7:1]};
						d.tx_bit = q.tx_bit + 3'h1;
						d.line.rd = q.tx_sh[1];
						if (q.tx_bit == (q.cfg.data8 ? 3'h7 : 3'h6)) begin
							d.tx_bit = 3'h0;
							if (rpc_par_on(q.cfg)) begin
								d.tx_st = TX_PAR;
								d.line.rd = q.tx_par;
							end else begin
								d.tx_st = TX_STOP;
								d.line.rd = 1'b1;
							end
						end
					end
				end
				TX_PAR: begin
					if (last) begin
						d.tx_st = TX_STOP;
						d.line.rd = 1'b1;
					end
				end
				TX_STOP: begin
					if (last) begin
						d.tx_bit = q.tx_bit + 3'h1;
						if (q.tx_bit == 3'(STOP_BITS_TX - 1)) begin
							d.tx_st = TX_IDLE;
						end
					end
				end
				default: begin
					d.tx_st = TX_IDLE;
					d.line.rd = 1'b1;
				end
			endcase
		end

		// Receiver, samples each bit at its middle
		if (tick) begin
			last = q.rx_ph == 4'(OVS - 1);
			d.rx_ph = q.rx_ph + 4'h1;
			case (q.rx_st)
				RX_IDLE: begin
					d.rx_ph = 4'h0;
					if (!td) begin
						d.rx_st = RX_START;
					end
				end
				RX_START: begin
					// A glitch shorter than half a bit is dropped
					if (q.rx_ph == 4'(OVS_MID)) begin
						d.rx_ph = 4'h0;
						d.rx_bit = 3'h0;
						d.rx_sh = 8'h00;
						d.rx_st = td ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (last) begin
						d.rx_sh[q.rx_bit] = td;
						d.rx_bit = q.rx_bit + 3'h1;
						if (q.rx_bit == (q.cfg.data8 ? 3'h7 : 3'h6)) begin
							d.rx_st = rpc_par_on(q.cfg) ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (last) begin
						d.rx_st = RX_STOP;
						if (td != rpc_parity(q.rx_sh, q.cfg)) begin
							d.perr = 1'b1;
						end
					end
				end
				RX_STOP: begin
					// Only the first stop bit is checked; more is idle line
					if (last) begin
						d.rx_st = RX_IDLE;
						if (!td) begin
							d.ferr = 1'b1;
						end
						if (d.rx_v) begin
							d.ovr = 1'b1;
						end else begin
							d.rx_data = q.rx_sh;
							d.rx_v = 1'b1;
							// Echo characters with a high stop bit back to a terminal, parity errors included
							if (td && q.cfg.interactive) begin
								d.echo = q.rx_sh;
								d.echo_v = 1'b1;
							end
						end
					end
				end
				default: begin
					d.rx_st = RX_IDLE;
				end
			endcase
		end

		// Line status outputs
		d.line.cts = !d.rx_v;
		d.line.dsr = 1'b1;
		d.line.rlsd = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// State register; line outputs at their powered levels from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.cfg <= CTRL_RESET;
			q.prompt <= PROMPT_RESET;
			q.tx_st <= TX_IDLE;
			q.rx_st <= RX_IDLE;
			q.line <= '1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign rd = q.line.rd;
	assign cts = q.line.cts;
	assign dsr = q.line.dsr;
	assign rlsd = q.line.rlsd;

endmodule

// ===== testbench/rpc_port_properties.sv
/* Assertions on the port's APB and line pins.
   Assumes binding onto rpc_port with its CLK_HZ. */
`timescale 1ns/10ps
module rpc_props import rpc_pkg::*; #(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	// Clock, reset and APB
	input wire logic pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic pready, pslverr,
	// Serial line
	input wire logic td, dtr, rd, cts, dsr, rlsd
);
	// Longer than any high run inside a frame at the slowest rate
	localparam int IDLE = 12 * 16 * ((CLK_HZ + 2400) / 4800);
	logic [23:0] hi_q;

	// High run length; saturates so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hi_q <= '0;
		else if (!rd) hi_q <= '0;
		else if (hi_q != '1) hi_q <= hi_q + 24'h1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc;
		psel && penable && !pready ##1 pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence

	a_dsr_on: assert property (dsr) else $error("dsr low");
	a_rlsd_on: assert property (rlsd) else $error("rlsd low");
	a_one_wait: assert property ($rose(penable) && psel |-> s_acc)
		else $error("no single wait state");
	a_ready_pulse: assert property (s_acc |=> !pready)
		else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_bad_addr: assert property (s_done ##0 (paddr > ADDR_CMD)
		|-> pslverr) else $error("unmapped accepted");
	a_wr_zero: assert property (s_done ##0 pwrite |-> prdata == 32'h0)
		else $error("prdata on write");
	a_cts_read: assert property (s_done ##0 (!pwrite &&
		paddr == ADDR_RXDATA) |=> cts) else $error("cts low after read");
	a_hold_dtr: assert property (hi_q > 24'(IDLE) && !dtr |=> rd)
		else $error("start without dtr");
endmodule

bind rpc_port rpc_props #(.CLK_HZ(CLK_HZ)) u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .td(td), .dtr(dtr), .rd(rd), .cts(cts),
	.dsr(dsr), .rlsd(rlsd));

// ===== testbench/rpc_term.sv
/* Terminal model on the far side of the serial line.
   Assumes the bench sets bit length bc and bit count nb. */
`timescale 1ns/10ps
module rpc_term (
	// Clock
	input wire logic pclk,
	// Serial line
	input wire logic rd,
	output logic td
);
	int bc = 32;
	int nb = 8;
	logic [9:0] rx_q[$];

	// Mark level while idle
	initial td = 1'b1;

	// Start low, eight data bits LSB first, a single stop bit
	task automatic send(input logic [7:0] b);
		td <= 1'b0;
		repeat (bc) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			td <= b[i];
			repeat (bc) @(posedge pclk);
		end
		td <= 1'b1;
		repeat (bc) @(posedge pclk);
	endtask

	// Mid-bit sampler; top bit flags both stop bits high
	initial begin : rx_p
		logic [8:0] v;
		logic s;
		forever begin
			@(negedge rd);
			v = '0;
			repeat (bc / 2) @(posedge pclk);
			for (int i = 0; i < nb; i++) begin
				repeat (bc) @(posedge pclk);
				v[i] = rd;
			end
			repeat (bc) @(posedge pclk);
			s = rd;
			repeat (bc) @(posedge pclk);
			rx_q.push_back({s & rd, v});
		end
	end
endmodule

// ===== testbench/rpc_port_bench.sv
/* Self-checking bench of the port: APB tasks and a terminal model.
   Assumes CLK_HZ of 307200, so one bit is 32 cycles at 9600. */
`timescale 1ns/10ps
module rpc_port_bench import rpc_pkg::*;;
	localparam int HZ = 307_200;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic dtr = 1, pready, pslverr, td, rd, cts, dsr, rlsd, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [9:0] v;
	int errors = 0, check_count = 0;
	// Format, byte sent, bits decoded, expected decode with stop flag
	logic [7:0] t_cfg[6] = '{8'h08, 8'h88, 8'h0A, 8'h19, 8'h2B, 8'h00};
	logic [7:0] t_tx[6] = '{8'h41, 8'hC5, 8'hC5, 8'h41, 8'h41, 8'hC1};
	int t_nb[6] = '{8, 8, 8, 9, 9, 7};
	logic [9:0] t_exp[6] = '{10'h241, 10'h2C5, 10'h245, 10'h241,
		10'h341, 10'h241};

	rpc_port #(.CLK_HZ(HZ)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .td(td), .dtr(dtr), .rd(rd), .cts(cts),
		.dsr(dsr), .rlsd(rlsd));
	rpc_term term (.pclk(pclk), .rd(rd), .td(td));

	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////
	// Bit length in cycles; only valid for HZ above
	function automatic int bits(input logic [2:0] s);
		return (s == 3'h0) ? 1024 : (s > 3'h3) ? 32 : 512 >> s;
	endfunction

	// One APB transfer; pready sampled at the edge itself
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// Bounded wait for one decoded character
	task automatic get(input logic [9:0] x);
		int n;
		n = 0;
		while (term.rx_q.size() == 0 && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		v = 10'h0;
		if (term.rx_q.size() != 0) v = term.rx_q.pop_front();
		chk({22'h0, v}, {22'h0, x});
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(r, 32'h4C);
		apb(1'b0, ADDR_PROMPT, 32'h0);
		chk(r, 32'h3E);
		chk({28'h0, cts, dsr, rlsd, rd}, 32'hF);
		apb(1'b0, 12'h018, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ADDR_CTRL, {24'h0, t_cfg[i]});
			term.bc = bits(t_cfg[i][2:0]);
			term.nb = t_nb[i];
			apb(1'b1, ADDR_TXDATA, {24'h0, t_tx[i]});
			get(t_exp[i]);
			repeat (term.bc) @(posedge pclk);
		end
		// 9600 baud, 8 bits, no parity, computer mode
		apb(1'b1, ADDR_CTRL, 32'h0C);
		// New rate takes hold only at the next tick of the old one
		repeat (64) @(posedge pclk);
		term.bc = 32;
		term.nb = 8;
		term.send(8'h5A);
		repeat (4) @(posedge pclk);
		chk({31'h0, cts}, 32'h0);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(r, 32'h41);
		apb(1'b0, ADDR_RXDATA, 32'h0);
		chk(r, 32'h5A);
		chk({31'h0, cts}, 32'h1);
		apb(1'b1, ADDR_CMD, 32'h1);
		repeat (400) @(posedge pclk);
		chk(32'(term.rx_q.size()), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h4C);
		apb(1'b1, ADDR_CMD, 32'h1);
		get(10'h23E);
		term.send(8'h33);
		get(10'h233);
		apb(1'b0, ADDR_RXDATA, 32'h0);
		dtr <= 1'b0;
		apb(1'b1, ADDR_TXDATA, 32'h55);
		repeat (13000) @(posedge pclk);
		chk(32'(term.rx_q.size()), 32'h0);
		dtr <= 1'b1;
		get(10'h255);
		stop_test();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#1_000_000;
		errors++;
		stop_test();
	end
endmodule
